// File: design/analog_config_register_page.sv
// Analog configuration register page: eight read/write byte registers.
// Assumes a synchronous control port on clk; writes take effect one edge on.
//
// Functional notes
// [RQ1] Offset 05 bit1 set disables external undervoltage detect.
// [RQ2] Offset 05 bit0 set disables internal undervoltage detect.
// [RQ3] Offset 06 bit0 couples analog to digital mute.
// [RQ4] Offset 07 bit4 boosts left amplitude ten percent.
// [RQ5] Offset 07 bit0 boosts right amplitude; resets set.
// [RQ6] Offset 08 bit4 selects fast bandgap ramp.
// [RQ7] Offset 08 bit0 selects fast common-mode ramp.
// [RQ8] Offset 09 bit1 lets shared pin control de-emphasis.
// [RQ9] Offset 09 bit0 powers common-mode reference down.
// [RQ10] Line bias bits 5-4 apply in bandgap mode.
// [RQ11] Line bias bits 1-0 apply in tracking mode.
// [RQ12] Feedback bias bits 5-4 apply in bandgap mode.
// [RQ13] Feedback bias bits 1-0 apply in tracking mode.
// [RQ14] Offset 01 bit0 selects reference mode.
// [RQ15] Registers read back written value; reset defaults.
`timescale 1ns/10ps
`include "analog_cfg_defines.svh"

module analog_config_register_page #(
    parameter int CLK_KHZ = 50000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire analog_cfg_pkg::cfg_access_s cfg_access,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    output analog_cfg_pkg::analog_ctrl_s analog_ctrl,
    output logic [31:0] bandgap_ramp_cycles,
    output logic [31:0] common_mode_ramp_cycles
);

    // ------------------------------------------------------------------------
    // Ramp time expressed in clock cycles
    // ------------------------------------------------------------------------

    // Nominal ramp durations are reported to the sequencer as cycle counts.
    localparam int BG_NORMAL_CYC = `BANDGAP_RAMP_NORMAL_US * (CLK_KHZ / 1000);
    localparam int BG_FAST_CYC = `BANDGAP_RAMP_FAST_US * (CLK_KHZ / 1000);
    localparam int CM_NORMAL_CYC = `CM_RAMP_NORMAL_US * (CLK_KHZ / 1000);
    localparam int CM_FAST_CYC = `CM_RAMP_FAST_US * (CLK_KHZ / 1000);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------

    // All registers of the page and the read answer, held in one record.
    typedef struct packed {
        logic [7:0] ref_mode;
        logic [7:0] uv_detect;
        logic [7:0] mute_follow;
        logic [7:0] amp_boost;
        logic [7:0] ramp_speed;
        logic [7:0] deemp_cm_power;
        logic [7:0] line_bias;
        logic [7:0] feedback_bias;
        logic [7:0] rdata;
        logic rvalid;
    } page_state_s;

    page_state_s state_q; // Registered page state.
    page_state_s state_d; // Next page state.
    analog_cfg_pkg::reg_sel_e sel; // Register addressed this cycle.
    logic [1:0] line_bias_sel; // Active line bias field.
    logic [1:0] feedback_bias_sel; // Active feedback bias field.

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------

    // Maps an offset to a register; bias offsets share one code, split later.
    function automatic analog_cfg_pkg::reg_sel_e decode(input logic [7:0] addr);
        case (addr)
            `OFS_REFERENCE_MODE: decode = analog_cfg_pkg::SEL_REF_MODE;
            `OFS_UV_DETECT: decode = analog_cfg_pkg::SEL_UV;
            `OFS_MUTE_FOLLOW: decode = analog_cfg_pkg::SEL_MUTE;
            `OFS_AMP_BOOST: decode = analog_cfg_pkg::SEL_BOOST;
            `OFS_RAMP_SPEED: decode = analog_cfg_pkg::SEL_RAMP;
            `OFS_DEEMP_CM_POWER: decode = analog_cfg_pkg::SEL_DEEMP;
            `OFS_LINE_BIAS, `OFS_FEEDBACK_BIAS: decode = analog_cfg_pkg::SEL_BIAS;
            default: decode = analog_cfg_pkg::SEL_NONE;
        endcase
    endfunction

    assign sel = decode(cfg_access.addr);

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // Writes store the whole byte, reserved bits included, with no side effect.
    always_comb begin
        state_d = state_q;
        state_d.rvalid = cfg_access.rd;
        state_d.rdata = 8'h00;
        if (cfg_access.wr) begin
            case (sel)
                analog_cfg_pkg::SEL_REF_MODE: begin
                    state_d.ref_mode = cfg_access.wdata; // [RQ14] [RQ15]
                end
                analog_cfg_pkg::SEL_UV: begin
                    state_d.uv_detect = cfg_access.wdata; // [RQ15]
                end
                analog_cfg_pkg::SEL_MUTE: begin
                    state_d.mute_follow = cfg_access.wdata; // [RQ15]
                end
                analog_cfg_pkg::SEL_BOOST: begin
                    state_d.amp_boost = cfg_access.wdata; // [RQ15]
                end
                analog_cfg_pkg::SEL_RAMP: begin
                    state_d.ramp_speed = cfg_access.wdata; // [RQ15]
                end
                analog_cfg_pkg::SEL_DEEMP: begin
                    state_d.deemp_cm_power = cfg_access.wdata; // [RQ15]
                end
                analog_cfg_pkg::SEL_BIAS: begin
                    // The full offset tells the two bias registers apart.
                    if (cfg_access.addr == `OFS_LINE_BIAS) begin
                        state_d.line_bias = cfg_access.wdata; // [RQ15]
                    end else begin
                        state_d.feedback_bias = cfg_access.wdata; // [RQ15]
                    end
                end
                default: begin
                    // Unmapped offsets ignore writes.
                end
            endcase
        end
        if (cfg_access.rd) begin
            case (sel)
                analog_cfg_pkg::SEL_REF_MODE: state_d.rdata = state_q.ref_mode;
                analog_cfg_pkg::SEL_UV: state_d.rdata = state_q.uv_detect;
                analog_cfg_pkg::SEL_MUTE: state_d.rdata = state_q.mute_follow;
                analog_cfg_pkg::SEL_BOOST: state_d.rdata = state_q.amp_boost;
                analog_cfg_pkg::SEL_RAMP: state_d.rdata = state_q.ramp_speed;
                analog_cfg_pkg::SEL_DEEMP: state_d.rdata = state_q.deemp_cm_power;
                analog_cfg_pkg::SEL_BIAS: begin
                    if (cfg_access.addr == `OFS_LINE_BIAS) begin
                        state_d.rdata = state_q.line_bias; // [RQ15]
                    end else begin
                        state_d.rdata = state_q.feedback_bias; // [RQ15]
                    end
                end
                default: state_d.rdata = 8'h00; // Unmapped offsets read zero.
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------

    // Reset loads the documented defaults of every register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q.ref_mode <= `RST_REFERENCE_MODE; // [RQ15]
            state_q.uv_detect <= `RST_UV_DETECT;
            state_q.mute_follow <= `RST_MUTE_FOLLOW;
            state_q.amp_boost <= `RST_AMP_BOOST;
            state_q.ramp_speed <= `RST_RAMP_SPEED;
            state_q.deemp_cm_power <= `RST_DEEMP_CM_POWER;
            state_q.line_bias <= `RST_LINE_BIAS;
            state_q.feedback_bias <= `RST_FEEDBACK_BIAS;
            state_q.rdata <= 8'h00;
            state_q.rvalid <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------------
    // Bias selection by reference mode
    // ------------------------------------------------------------------------

    // The mux follows the reference mode bit without extra delay.
    analog_bias_mux i_analog_bias_mux (
        .line_bias_reg(state_q.line_bias),
        .feedback_bias_reg(state_q.feedback_bias),
        .supply_tracking_mode(state_q.ref_mode[`BIT_REFERENCE_MODE]), // [RQ14]
        .line_bias(line_bias_sel),
        .feedback_bias(feedback_bias_sel)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    assign cfg_rdata = state_q.rdata;
    assign cfg_rvalid = state_q.rvalid;

    // Control levels come straight from register bits.
    always_comb begin
        analog_ctrl.external_uv_detect_off = state_q.uv_detect[`BIT_EXT_UV_OFF]; // [RQ1]
        analog_ctrl.internal_uv_detect_off = state_q.uv_detect[`BIT_INT_UV_OFF]; // [RQ2]
        analog_ctrl.analog_mute_follow_en = state_q.mute_follow[`BIT_MUTE_FOLLOW]; // [RQ3]
        analog_ctrl.left_amplitude_boost = state_q.amp_boost[`BIT_LEFT_BOOST]; // [RQ4]
        analog_ctrl.right_amplitude_boost = state_q.amp_boost[`BIT_RIGHT_BOOST]; // [RQ5]
        analog_ctrl.bandgap_fast_ramp = state_q.ramp_speed[`BIT_BANDGAP_FAST]; // [RQ6]
        analog_ctrl.common_mode_fast_ramp = state_q.ramp_speed[`BIT_CM_FAST]; // [RQ7]
        analog_ctrl.deemphasis_pin_use = state_q.deemp_cm_power[`BIT_DEEMP_PIN_USE]; // [RQ8]
        analog_ctrl.common_mode_power_down =
            state_q.deemp_cm_power[`BIT_CM_POWER_DOWN]; // [RQ9]
        analog_ctrl.reference_mode_select = state_q.ref_mode[`BIT_REFERENCE_MODE]; // [RQ14]
        analog_ctrl.line_bias = line_bias_sel;
        analog_ctrl.feedback_bias = feedback_bias_sel;
    end

    // Ramp duration follows the selected speed.
    assign bandgap_ramp_cycles = analog_ctrl.bandgap_fast_ramp ?
        32'(BG_FAST_CYC) : 32'(BG_NORMAL_CYC); // [RQ6]
    assign common_mode_ramp_cycles = analog_ctrl.common_mode_fast_ramp ?
        32'(CM_FAST_CYC) : 32'(CM_NORMAL_CYC); // [RQ7]

endmodule

// File: design/analog_cfg_defines.svh
// Offsets, field positions and reset values of the analog configuration page.
// Assumes it is included by bare name from design files; definitions only.
`ifndef ANALOG_CFG_DEFINES_SVH
`define ANALOG_CFG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets within the page
// ----------------------------------------------------------------------------
`define OFS_REFERENCE_MODE 8'h01
`define OFS_UV_DETECT 8'h05
`define OFS_MUTE_FOLLOW 8'h06
`define OFS_AMP_BOOST 8'h07
`define OFS_RAMP_SPEED 8'h08
`define OFS_DEEMP_CM_POWER 8'h09
`define OFS_LINE_BIAS 8'h0A
`define OFS_FEEDBACK_BIAS 8'h0B

// ----------------------------------------------------------------------------
// Reset values of whole registers
// ----------------------------------------------------------------------------
`define RST_REFERENCE_MODE 8'h00
`define RST_UV_DETECT 8'h00
`define RST_MUTE_FOLLOW 8'h01
`define RST_AMP_BOOST 8'h01
`define RST_RAMP_SPEED 8'h01
`define RST_DEEMP_CM_POWER 8'h01
`define RST_LINE_BIAS 8'h11
`define RST_FEEDBACK_BIAS 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_REFERENCE_MODE 0
`define BIT_EXT_UV_OFF 1
`define BIT_INT_UV_OFF 0
`define BIT_MUTE_FOLLOW 0
`define BIT_LEFT_BOOST 4
`define BIT_RIGHT_BOOST 0
`define BIT_BANDGAP_FAST 4
`define BIT_CM_FAST 0
`define BIT_DEEMP_PIN_USE 1
`define BIT_CM_POWER_DOWN 0
`define BIAS_HI_MSB 5
`define BIAS_HI_LSB 4
`define BIAS_LO_MSB 1
`define BIAS_LO_LSB 0

// ----------------------------------------------------------------------------
// Ramp times in microseconds, nominal
// ----------------------------------------------------------------------------
`define BANDGAP_RAMP_NORMAL_US 50000
`define BANDGAP_RAMP_FAST_US 1000
`define CM_RAMP_NORMAL_US 600000
`define CM_RAMP_FAST_US 3000

`endif

// File: design/analog_cfg_pkg.sv
// Types shared by the analog configuration page files.
// Assumes nothing of its surroundings.
package analog_cfg_pkg;

    // ------------------------------------------------------------------------
    // Control port access and resolved analog control levels
    // ------------------------------------------------------------------------

    // One register access from the control port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_access_s;

    // Static levels driven into the analog section.
    typedef struct packed {
        logic       external_uv_detect_off;
        logic       internal_uv_detect_off;
        logic       analog_mute_follow_en;
        logic       left_amplitude_boost;
        logic       right_amplitude_boost;
        logic       bandgap_fast_ramp;
        logic       common_mode_fast_ramp;
        logic       deemphasis_pin_use;
        logic       common_mode_power_down;
        logic       reference_mode_select;
        logic [1:0] line_bias;
        logic [1:0] feedback_bias;
    } analog_ctrl_s;

    // Decoded register being accessed.
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_REF_MODE,
        SEL_UV,
        SEL_MUTE,
        SEL_BOOST,
        SEL_RAMP,
        SEL_DEEMP,
        SEL_BIAS
    } reg_sel_e;

endpackage

// File: design/analog_bias_mux.sv
// Picks the active bias fields from the reference mode.
// Assumes register values arrive from flip-flops in the page module.
`timescale 1ns/10ps
`include "analog_cfg_defines.svh"

module analog_bias_mux (
    input wire logic [7:0] line_bias_reg,
    input wire logic [7:0] feedback_bias_reg,
    input wire logic supply_tracking_mode,
    output logic [1:0] line_bias,
    output logic [1:0] feedback_bias
);

    // ------------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------------

    // Bandgap mode uses the upper fields, supply tracking mode the lower ones.
    always_comb begin
        if (supply_tracking_mode) begin
            line_bias = line_bias_reg[`BIAS_LO_MSB:`BIAS_LO_LSB]; // [RQ11]
            feedback_bias = feedback_bias_reg[`BIAS_LO_MSB:`BIAS_LO_LSB]; // [RQ13]
        end else begin
            line_bias = line_bias_reg[`BIAS_HI_MSB:`BIAS_HI_LSB]; // [RQ10]
            feedback_bias = feedback_bias_reg[`BIAS_HI_MSB:`BIAS_HI_LSB]; // [RQ12]
        end
    end

endmodule

// File: dv/analog_cfg_chk.sv
// Concurrent checks on the analog configuration page ports.
// Assumes it is bound to the page module and sees only its ports.
`timescale 1ns/10ps

module analog_cfg_chk #(
    parameter int CLK_KHZ = 50000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire analog_cfg_pkg::cfg_access_s cfg_access,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire analog_cfg_pkg::analog_ctrl_s analog_ctrl,
    input wire logic [31:0] bandgap_ramp_cycles,
    input wire logic [31:0] common_mode_ramp_cycles
);
    // ------------------------------------------------------------------------
    // Clocking and helper logic
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic [7:0] wd_q; // Write data of the previous cycle.

    // Keeps the last write data so a check can compare it one edge later.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wd_q <= 8'h00;
        end else begin
            wd_q <= cfg_access.wdata;
        end
    end

    // A read strobe, and a write strobe aimed at one offset.
    sequence rd_req;
        cfg_access.rd;
    endsequence
    sequence wr_to(logic [7:0] a);
        cfg_access.wr && cfg_access.addr == a;
    endsequence

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    chk_read_answer: assert property (rd_req |=> cfg_rvalid)
        else $error("read without answer");
    chk_stray_answer: assert property (
        !cfg_access.rd |=> !cfg_rvalid && cfg_rdata == 8'h00)
        else $error("answer without read");
    chk_unmapped_zero: assert property (
        cfg_access.rd && !(cfg_access.addr inside {8'h01, [8'h05:8'h0B]})
        |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_mode_write: assert property (
        wr_to(8'h01) |=> analog_ctrl.reference_mode_select == wd_q[0])
        else $error("mode bit not taken");
    chk_uv_write: assert property (
        wr_to(8'h05) |=> analog_ctrl.external_uv_detect_off == wd_q[1]
        && analog_ctrl.internal_uv_detect_off == wd_q[0])
        else $error("undervoltage bits not taken");
    chk_mute_write: assert property (
        wr_to(8'h06) |=> analog_ctrl.analog_mute_follow_en == wd_q[0])
        else $error("mute follow bit not taken");
    chk_boost_write: assert property (
        wr_to(8'h07) |=> analog_ctrl.left_amplitude_boost == wd_q[4]
        && analog_ctrl.right_amplitude_boost == wd_q[0])
        else $error("boost bits not taken");
    chk_ramp_write: assert property (
        wr_to(8'h08) |=> analog_ctrl.bandgap_fast_ramp == wd_q[4]
        && analog_ctrl.common_mode_fast_ramp == wd_q[0])
        else $error("ramp bits not taken");
    chk_deemp_write: assert property (
        wr_to(8'h09) |=> analog_ctrl.deemphasis_pin_use == wd_q[1]
        && analog_ctrl.common_mode_power_down == wd_q[0])
        else $error("pin use or power down not taken");
    chk_line_bias: assert property (
        wr_to(8'h0A) |=> analog_ctrl.line_bias ==
        (analog_ctrl.reference_mode_select ? wd_q[1:0] : wd_q[5:4]))
        else $error("line bias wrong field");
    chk_fb_bias: assert property (
        wr_to(8'h0B) |=> analog_ctrl.feedback_bias ==
        (analog_ctrl.reference_mode_select ? wd_q[1:0] : wd_q[5:4]))
        else $error("feedback bias wrong field");
    chk_levels_hold: assert property (!cfg_access.wr |=> $stable(analog_ctrl))
        else $error("level moved without write");
    chk_ramp_count: assert property (
        bandgap_ramp_cycles ==
        32'((analog_ctrl.bandgap_fast_ramp ? 1000 : 50000) * (CLK_KHZ / 1000)))
        else $error("bandgap ramp count wrong");
    chk_cm_ramp_count: assert property (
        common_mode_ramp_cycles ==
        32'((analog_ctrl.common_mode_fast_ramp ? 3000 : 600000) * (CLK_KHZ / 1000)))
        else $error("common-mode ramp count wrong");
endmodule

bind analog_config_register_page analog_cfg_chk #(.CLK_KHZ(CLK_KHZ)) i_analog_cfg_chk (
    .clk(clk),
    .resetn(resetn),
    .cfg_access(cfg_access),
    .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid),
    .analog_ctrl(analog_ctrl),
    .bandgap_ramp_cycles(bandgap_ramp_cycles),
    .common_mode_ramp_cycles(common_mode_ramp_cycles)
);

// File: dv/analog_config_register_page_tb.sv
// Self-checking bench for the analog configuration page.
// Assumes the page module and its package are compiled before it.
`timescale 1ns/10ps

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

module analog_config_register_page_tb;
    // ------------------------------------------------------------------------
    // Signals and shadow copy of the page
    // ------------------------------------------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    analog_cfg_pkg::cfg_access_s acc = '0;
    logic [7:0] rdata;
    logic rvalid;
    analog_cfg_pkg::analog_ctrl_s ctrl;
    logic [31:0] bg_cycles;
    logic [31:0] cm_cycles;
    int fails = 0;
    int tests_run = 0;
    logic [7:0] sh [0:15]; // Expected content of every mapped offset.
    logic [7:0] regs [8] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B};
    logic [7:0] pat [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};

    // Free-running 50 MHz clock.
    always #10 clk = ~clk;

    analog_config_register_page i_analog_config_register_page (
        .clk(clk),
        .resetn(resetn),
        .cfg_access(acc),
        .cfg_rdata(rdata),
        .cfg_rvalid(rvalid),
        .analog_ctrl(ctrl),
        .bandgap_ramp_cycles(bg_cycles),
        .common_mode_ramp_cycles(cm_cycles)
    );

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    // Loads the documented reset contents into the shadow copy.
    task automatic init_sh();
        sh[1] = 8'h00;
        sh[5] = 8'h00;
        sh[6] = 8'h01;
        sh[7] = 8'h01;
        sh[8] = 8'h01;
        sh[9] = 8'h01;
        sh[10] = 8'h11;
        sh[11] = 8'h10;
    endtask

    // Works out the analog levels from the shadow copy.
    function automatic analog_cfg_pkg::analog_ctrl_s exp_ctrl();
        analog_cfg_pkg::analog_ctrl_s e;
        e.external_uv_detect_off = sh[5][1];
        e.internal_uv_detect_off = sh[5][0];
        e.analog_mute_follow_en = sh[6][0];
        e.left_amplitude_boost = sh[7][4];
        e.right_amplitude_boost = sh[7][0];
        e.bandgap_fast_ramp = sh[8][4];
        e.common_mode_fast_ramp = sh[8][0];
        e.deemphasis_pin_use = sh[9][1];
        e.common_mode_power_down = sh[9][0];
        e.reference_mode_select = sh[1][0];
        e.line_bias = sh[1][0] ? sh[10][1:0] : sh[10][5:4];
        e.feedback_bias = sh[1][0] ? sh[11][1:0] : sh[11][5:4];
        return e;
    endfunction

    // One write strobe; mapped offsets update the shadow copy.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        acc.wr <= 1'b1;
        acc.addr <= a;
        acc.wdata <= d;
        @(posedge clk);
        acc.wr <= 1'b0;
        if (a inside {8'h01, [8'h05:8'h0B]}) begin
            sh[a[3:0]] = d;
        end
    endtask

    // One read strobe; the answer is looked at in the cycle after it.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        acc.rd <= 1'b1;
        acc.addr <= a;
        @(posedge clk);
        acc.rd <= 1'b0;
        #1;
        `CHK("read valid", 1'b1, rvalid)
        `CHK("read data", e, rdata)
    endtask

    // Writes and reads one offset in the same cycle; the read sees the old byte.
    task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] old;
        old = sh[a[3:0]];
        @(posedge clk);
        acc.wr <= 1'b1;
        acc.rd <= 1'b1;
        acc.addr <= a;
        acc.wdata <= d;
        @(posedge clk);
        acc.wr <= 1'b0;
        acc.rd <= 1'b0;
        sh[a[3:0]] = d;
        #1;
        `CHK("joint read valid", 1'b1, rvalid)
        `CHK("joint read old data", old, rdata)
    endtask

    // Reads back every register and compares all levels and ramp counts.
    task automatic chk_all();
        foreach (regs[j]) begin
            rd_chk(regs[j], sh[regs[j][3:0]]);
        end
        `CHK("analog levels", exp_ctrl(), ctrl)
        `CHK("bandgap ramp", 32'((sh[8][4] ? 1000 : 50000) * 50), bg_cycles)
        `CHK("cm ramp", 32'((sh[8][0] ? 3000 : 600000) * 50), cm_cycles)
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    // Main sequence of tests.
    initial begin
        init_sh();
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        chk_all();
        $display("test reset values done");
        foreach (pat[i]) begin
            foreach (regs[j]) begin
                wr_reg(regs[j], pat[i]);
            end
            chk_all();
        end
        $display("test write patterns done");
        wr_reg(8'h0A, 8'h21);
        wr_reg(8'h0B, 8'h12);
        wr_reg(8'h01, 8'h00);
        chk_all();
        wr_reg(8'h01, 8'h01);
        chk_all();
        $display("test bias mode select done");
        wr_reg(8'h02, 8'hFF);
        wr_reg(8'h0C, 8'hFF);
        wr_rd_chk(8'h07, 8'h11);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h0C, 8'h00);
        chk_all();
        $display("test unmapped offsets done");
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        init_sh();
        chk_all();
        $display("test second reset done");
        end_of_test();
    end

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #400000;
        fails++;
        end_of_test();
    end
endmodule
